// file: lmps_pkg.sv
// package for the local memory pin sequencer: states, timing, reset values
// assumes a single 10 MHz bus clock feeds every user of these constants
package lmps_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned WR_SETUP_NS    = 100;
    localparam int unsigned WR_SETUP_CYC   =
        (WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STATIC_ADDR_LO = 2;
    localparam int unsigned STATIC_ADDR_HI = 13;
    localparam int unsigned MUX_W          = 12;
    localparam int unsigned BEAT_W         = 4;
    localparam logic [3:0]  STROBE4_IDLE   = 4'hF;
    localparam logic [7:0]  STROBE8_IDLE   = 8'hFF;
    localparam logic [1:0]  STROBE2_IDLE   = 2'h3;
    localparam logic [11:0] MUX_RESET      = 12'h000;
    localparam logic [3:0]  PAR_RESET      = 4'h0;

    typedef enum logic [1:0] {
        LMPS_ACC_STATIC,
        LMPS_ACC_DRAM,
        LMPS_ACC_REFRESH
    } lmps_acc_t;

    typedef enum logic [2:0] {
        LMPS_IDLE,
        LMPS_S_DATA,
        LMPS_S_WREND,
        LMPS_D_ROW,
        LMPS_D_COL,
        LMPS_D_DONE
    } lmps_state_t;
endpackage

// file: lmps_parity.sv
// per-byte parity generator and checker for the dram data lanes
// assumes data and enables are stable in the cycle they are presented
`timescale 1ns/1ps
module lmps_parity (
    input  wire logic [31:0] data_in,
    input  wire logic [3:0]  lane_en_in,
    input  wire logic        odd_in,
    input  wire logic [3:0]  par_in,
    output logic      [3:0]  par_out,
    output logic             err_out
);
    logic [3:0] mism;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            par_out[i] = (^data_in[i*8 +: 8]) ^ odd_in;
            // only enabled lanes may flag a mismatch
            mism[i] = lane_en_in[i] & (par_out[i] != par_in[i]);
        end
        err_out = |mism;
    end
endmodule

// file: lmps_sequencer.sv
// local memory pin sequencer: static bank and dram pin timing
// assumes requests are synchronous to clk_in and held until done_out
//
// Functional notes
// - static banks output byte address 13:2
// - static burst advances address each beat
// - dram drives twelve row/column mux bits
// - write data held through strobe rising edge
// - one static write strobe per byte lane
// - row strobe with valid row address, all on refresh
// - row strobe released after last transfer
// - non-interleaved: row strobe k selects bank k
// - static selects exclusive, held whole operation
// - column strobes with column address, all on refresh
// - both dram write enables equal, low on writes
// - parity per byte, error flag next clock
`timescale 1ns/1ps
module lmps_sequencer (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        req_in,
    input  wire logic [1:0]  req_kind_in,
    input  wire logic        req_write_in,
    input  wire logic [31:0] req_addr_in,
    input  wire logic [3:0]  byte_lane_enable_n_in,
    input  wire logic [3:0]  req_beats_in,
    input  wire logic        static_bank_in,
    input  wire logic [1:0]  dram_bank_in,
    input  wire logic        interleave_in,
    input  wire logic [11:0] row_addr_in,
    input  wire logic [11:0] col_addr_in,
    input  wire logic        parity_odd_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic [31:0] local_addr_data_in,
    input  wire logic [3:0]  byte_parity_in,
    output logic             done_out,
    output logic             busy_out,
    output logic      [11:0] mem_mux_addr_out,
    output logic      [3:0]  static_write_strobe_n_out,
    output logic      [1:0]  static_bank_select_n_out,
    output logic      [3:0]  row_strobe_n_out,
    output logic      [7:0]  col_strobe_n_out,
    output logic      [1:0]  dram_write_n_out,
    output logic      [31:0] local_addr_data_out,
    output logic             local_addr_data_oe_out,
    output logic      [3:0]  byte_parity_out,
    output logic             byte_parity_oe_out,
    output logic             parity_err_out
);
    typedef struct packed {
        lmps_pkg::lmps_state_t st;
        logic                  wr;
        logic [3:0]            lanes;
        logic [3:0]            beats;
        logic [1:0]            bank;
        logic                  ilv;
        logic [11:0]           col;
        logic                  chk;
        logic                  done;
        logic [11:0]           ma;
        logic [3:0]            mwe_n;
        logic [1:0]            ce_n;
        logic [3:0]            ras_n;
        logic [7:0]            cas_n;
        logic [1:0]            dwe_n;
        logic [31:0]           dout;
        logic                  doe;
        logic [3:0]            pout;
        logic                  poe;
        logic                  perr;
    } lmps_regs_t;

    lmps_regs_t s_reg;
    lmps_regs_t s_next;
    logic [3:0] gen_par;
    logic       chk_err;
    logic [3:0] lane_on;

    assign lane_on = ~byte_lane_enable_n_in;

    // write parity follows the captured word; only the odd/even select comes live from parity_odd_in
    lmps_parity u_par (
        .data_in    (s_reg.chk ? local_addr_data_in : s_reg.dout),
        .lane_en_in (s_reg.lanes),
        .odd_in     (parity_odd_in),
        .par_in     (byte_parity_in),
        .par_out    (gen_par),
        .err_out    (chk_err)
    );

    function automatic logic [3:0] ras_sel(input logic ilv,
                                           input logic [1:0] bank);
        logic [3:0] r;
        r = lmps_pkg::STROBE4_IDLE;
        if (ilv) begin
            // leaf chosen by bank bit 0; bit 1 picks the pair member
            r[{bank[1], bank[0]}] = 1'b0;
        end else begin
            r[bank] = 1'b0;
        end
        return r;
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.chk = 1'b0;
        // error shows the clock after the read data cycle
        s_next.perr = s_reg.chk & chk_err;
        unique case (s_reg.st)
            lmps_pkg::LMPS_IDLE: begin
                if (req_in) begin
                    s_next.wr = req_write_in;
                    s_next.lanes = lane_on;
                    s_next.beats = req_beats_in;
                    s_next.bank = dram_bank_in;
                    s_next.ilv = interleave_in;
                    s_next.col = col_addr_in;
                    s_next.dout = wdata_in;
                    if (req_kind_in == 2'(lmps_pkg::LMPS_ACC_STATIC)) begin
                        s_next.ma = req_addr_in[lmps_pkg::STATIC_ADDR_HI:
                                               lmps_pkg::STATIC_ADDR_LO];
                        s_next.ce_n = static_bank_in ? 2'h1 : 2'h2;
                        s_next.doe = req_write_in;
                        s_next.mwe_n = req_write_in ? ~lane_on
                                     : lmps_pkg::STROBE4_IDLE;
                        s_next.st = lmps_pkg::LMPS_S_DATA;
                    end else if (req_kind_in ==
                                 2'(lmps_pkg::LMPS_ACC_REFRESH)) begin
                        s_next.cas_n = 8'h00;
                        s_next.ras_n = 4'h0;
                        s_next.st = lmps_pkg::LMPS_D_DONE;
                    end else begin
                        s_next.ma = row_addr_in;
                        s_next.ras_n = ras_sel(interleave_in,
                                               dram_bank_in);
                        s_next.st = lmps_pkg::LMPS_D_ROW;
                    end
                end
            end
            lmps_pkg::LMPS_S_DATA: begin
                if (s_reg.wr) begin
                    // strobe rises while data and address still driven
                    s_next.mwe_n = lmps_pkg::STROBE4_IDLE;
                    s_next.st = lmps_pkg::LMPS_S_WREND;
                end else if (s_reg.beats == 4'h0) begin
                    s_next.ce_n = lmps_pkg::STROBE2_IDLE;
                    s_next.done = 1'b1;
                    s_next.st = lmps_pkg::LMPS_IDLE;
                end else begin
                    s_next.beats = s_reg.beats - 4'h1;
                    s_next.ma = s_reg.ma + 12'h001;
                end
            end
            lmps_pkg::LMPS_S_WREND: begin
                if (s_reg.beats == 4'h0) begin
                    s_next.ce_n = lmps_pkg::STROBE2_IDLE;
                    s_next.doe = 1'b0;
                    s_next.done = 1'b1;
                    s_next.st = lmps_pkg::LMPS_IDLE;
                end else begin
                    s_next.beats = s_reg.beats - 4'h1;
                    s_next.ma = s_reg.ma + 12'h001;
                    s_next.dout = wdata_in;
                    s_next.mwe_n = ~s_reg.lanes;
                    s_next.st = lmps_pkg::LMPS_S_DATA;
                end
            end
            lmps_pkg::LMPS_D_ROW: begin
                s_next.ma = s_reg.col;
                s_next.dwe_n = s_reg.wr ? 2'h0 : 2'h3;
                s_next.doe = s_reg.wr;
                s_next.poe = s_reg.wr;
                s_next.pout = gen_par;
                s_next.st = lmps_pkg::LMPS_D_COL;
            end
            lmps_pkg::LMPS_D_COL: begin
                // interleaved: lanes map to 0-3 or 4-7 depending on the leaf; non-interleaved: both halves
                s_next.cas_n = ~((s_reg.ilv && s_reg.bank[0])
                               ? {s_reg.lanes, 4'h0}
                               : (s_reg.ilv ? {4'h0, s_reg.lanes}
                                  : {s_reg.lanes, s_reg.lanes}));
                s_next.chk = ~s_reg.wr;
                s_next.st = lmps_pkg::LMPS_D_DONE;
            end
            lmps_pkg::LMPS_D_DONE: begin
                s_next.ras_n = lmps_pkg::STROBE4_IDLE;
                s_next.cas_n = lmps_pkg::STROBE8_IDLE;
                s_next.dwe_n = lmps_pkg::STROBE2_IDLE;
                s_next.doe = 1'b0;
                s_next.poe = 1'b0;
                s_next.done = 1'b1;
                s_next.st = lmps_pkg::LMPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_reg <= '{st: lmps_pkg::LMPS_IDLE, wr: 1'b0, lanes: 4'h0,
                       beats: 4'h0, bank: 2'h0, ilv: 1'b0, col: 12'h000,
                       chk: 1'b0, done: 1'b0, ma: lmps_pkg::MUX_RESET,
                       mwe_n: lmps_pkg::STROBE4_IDLE,
                       ce_n: lmps_pkg::STROBE2_IDLE,
                       ras_n: lmps_pkg::STROBE4_IDLE,
                       cas_n: lmps_pkg::STROBE8_IDLE,
                       dwe_n: lmps_pkg::STROBE2_IDLE, dout: 32'h0000_0000,
                       doe: 1'b0, pout: lmps_pkg::PAR_RESET, poe: 1'b0,
                       perr: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign done_out = s_reg.done;
    assign busy_out = (s_reg.st != lmps_pkg::LMPS_IDLE);
    assign mem_mux_addr_out = s_reg.ma;
    assign static_write_strobe_n_out = s_reg.mwe_n;
    assign static_bank_select_n_out = s_reg.ce_n;
    assign row_strobe_n_out = s_reg.ras_n;
    assign col_strobe_n_out = s_reg.cas_n;
    assign dram_write_n_out = s_reg.dwe_n;
    assign local_addr_data_out = s_reg.dout;
    assign local_addr_data_oe_out = s_reg.doe;
    assign byte_parity_out = s_reg.pout;
    assign byte_parity_oe_out = s_reg.poe;
    assign parity_err_out = s_reg.perr;

    selects_excl_a: assert property (@(posedge clk_in) disable iff (rst_in)
        static_bank_select_n_out != 2'h0)
        else $error("both static selects low");
    wdata_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $rose(&static_write_strobe_n_out) |-> local_addr_data_oe_out)
        else $error("write data dropped before strobe rise");
    strobe_lane_a: assert property (@(posedge clk_in) disable iff (rst_in)
        static_bank_select_n_out != 2'h3 |->
        (~static_write_strobe_n_out & ~s_reg.lanes) == 4'h0)
        else $error("write strobe on disabled lane");
    burst_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
        s_reg.st == lmps_pkg::LMPS_S_WREND && s_reg.beats != 4'h0 |=>
        mem_mux_addr_out == $past(mem_mux_addr_out) + 12'h001)
        else $error("burst address did not advance");
    row_before_col_a: assert property (@(posedge clk_in) disable iff (rst_in)
        s_reg.st == lmps_pkg::LMPS_D_ROW && s_reg.ras_n != 4'hF |=>
        ##1 col_strobe_n_out != 8'hFF)
        else $error("column strobe missing after row");
    ras_release_a: assert property (@(posedge clk_in) disable iff (rst_in)
        s_reg.st == lmps_pkg::LMPS_D_DONE |=>
        row_strobe_n_out == 4'hF && done_out)
        else $error("row strobe not released");
    dwe_equal_a: assert property (@(posedge clk_in) disable iff (rst_in)
        dram_write_n_out[0] == dram_write_n_out[1])
        else $error("dram write enables differ");
    perr_timing_a: assert property (@(posedge clk_in) disable iff (rst_in)
        s_reg.chk && chk_err |=> parity_err_out)
        else $error("parity error not flagged next clock");
    ras_one_a: assert property (@(posedge clk_in) disable iff (rst_in)
        s_reg.st == lmps_pkg::LMPS_D_ROW |-> $onehot(~row_strobe_n_out))
        else $error("row strobe select not one-hot");

    cov_static_wr_c: cover property (@(posedge clk_in)
        s_reg.st == lmps_pkg::LMPS_S_WREND);
    cov_dram_rd_c: cover property (@(posedge clk_in)
        s_reg.st == lmps_pkg::LMPS_D_COL && !s_reg.wr);
    cov_refresh_c: cover property (@(posedge clk_in)
        col_strobe_n_out == 8'h00);
    cov_perr_c: cover property (@(posedge clk_in) parity_err_out);
endmodule

// file: lmps_mem_model.sv
// memory model: static write capture, dram read data with byte parity
// assumes dut strobes are registered on clk_in, parity polarity even
`timescale 1ns/1ps
module lmps_mem_model (
    input  wire logic        clk_in,
    input  wire logic [3:0]  wr_strobe_n_in,
    input  wire logic [7:0]  col_strobe_n_in,
    input  wire logic [1:0]  dram_write_n_in,
    input  wire logic [31:0] bus_in,
    input  wire logic        bad_par_in,
    output logic      [31:0] rdata_out,
    output logic      [3:0]  rpar_out,
    output logic      [31:0] cap_out
);
    localparam logic [31:0] PAT = 32'hA5C3_1E69;
    logic [3:0]  prev_n = 4'hF;
    logic [31:0] last_d = 32'h0000_0000;
    logic [3:0]  last_p = 4'h0;
    logic        drive;
    initial cap_out = 32'h0000_0000;
    // lane data taken on the strobe's rising edge only
    always @(wr_strobe_n_in) begin
        for (int i = 0; i < 4; i++) begin
            if (prev_n[i] === 1'b0 && wr_strobe_n_in[i] === 1'b1)
                cap_out[8*i+:8] = bus_in[8*i+:8];
        end
        prev_n = wr_strobe_n_in;
    end
    assign drive = (col_strobe_n_in != 8'hFF) && (dram_write_n_in == 2'h3);
    // released lines toggle so a stale value can never pass
    always_comb begin
        rdata_out = drive ? PAT : ~last_d;
        rpar_out  = drive ? {^PAT[31:24], ^PAT[23:16], ^PAT[15:8],
                             ^PAT[7:0] ^ bad_par_in} : ~last_p;
    end
    always @(posedge clk_in) begin
        last_d <= rdata_out;
        last_p <= rpar_out;
    end
endmodule

// file: test_lmps_sequencer.sv
// testbench for the pin sequencer, one task per access kind and direction
// assumes lmps_mem_model answers on the memory side
`timescale 1ns/1ps
module test_lmps_sequencer;
    logic clk_in = 1'b0, rst_in = 1'b1, req_in = 1'b0, req_write_in = 1'b0;
    logic static_bank_in = 1'b0, interleave_in = 1'b0, parity_odd_in = 1'b0;
    logic [1:0]  req_kind_in = 2'h0, dram_bank_in = 2'h0;
    logic [3:0]  byte_lane_enable_n_in = 4'hF, req_beats_in = 4'h0;
    logic [11:0] row_addr_in = 12'h000, col_addr_in = 12'h000;
    logic [31:0] req_addr_in = 32'h0, wdata_in = 32'h0;
    logic [31:0] local_addr_data_in, local_addr_data_out, cap;
    logic [3:0]  byte_parity_in, byte_parity_out, static_write_strobe_n_out;
    logic [3:0]  row_strobe_n_out;
    logic [11:0] mem_mux_addr_out;
    logic [7:0]  col_strobe_n_out;
    logic [1:0]  static_bank_select_n_out, dram_write_n_out;
    logic done_out, busy_out, local_addr_data_oe_out, byte_parity_oe_out;
    logic parity_err_out, bad = 1'b0;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    lmps_sequencer i_dut (.clk_in, .rst_in, .req_in, .req_kind_in,
        .req_write_in, .req_addr_in, .byte_lane_enable_n_in, .req_beats_in,
        .static_bank_in, .dram_bank_in, .interleave_in, .row_addr_in,
        .col_addr_in, .parity_odd_in, .wdata_in, .local_addr_data_in,
        .byte_parity_in, .done_out, .busy_out, .mem_mux_addr_out,
        .static_write_strobe_n_out, .static_bank_select_n_out,
        .row_strobe_n_out, .col_strobe_n_out, .dram_write_n_out,
        .local_addr_data_out, .local_addr_data_oe_out, .byte_parity_out,
        .byte_parity_oe_out, .parity_err_out);
    lmps_mem_model i_mem (.clk_in, .wr_strobe_n_in(static_write_strobe_n_out),
        .col_strobe_n_in(col_strobe_n_out), .dram_write_n_in(dram_write_n_out),
        .bus_in(local_addr_data_out), .bad_par_in(bad),
        .rdata_out(local_addr_data_in), .rpar_out(byte_parity_in),
        .cap_out(cap));
    initial forever #50 clk_in = ~clk_in;
    task automatic summarize();
        $display("checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // a hung handshake would otherwise stall the run forever
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic nx();
        @(negedge clk_in);
    endtask
    task automatic go(input logic [1:0] k, input logic w);
        req_kind_in = k;
        req_write_in = w;
        req_in = 1'b1;
        nx();
        req_in = 1'b0;
    endtask
    task automatic t_swrite();
        static_bank_in = 1'b1;
        req_addr_in = 32'h0000_3AB4;
        byte_lane_enable_n_in = 4'hA;
        wdata_in = 32'h1234_5678;
        req_beats_in = 4'h1;
        go(2'h0, 1'b1);
        chk(static_bank_select_n_out, 2'h1);
        chk(mem_mux_addr_out, 12'hEAD);
        chk(static_write_strobe_n_out, 4'hA);
        chk(local_addr_data_out, 32'h1234_5678);
        chk(local_addr_data_oe_out, 1'b1);
        chk(busy_out, 1'b1);
        nx();
        chk(static_write_strobe_n_out, 4'hF);
        chk(static_bank_select_n_out, 2'h1);
        wdata_in = 32'h9ABC_DEF0;
        nx();
        chk(mem_mux_addr_out, 12'hEAE);
        chk(static_write_strobe_n_out, 4'hA);
        chk(cap, 32'h0034_0078);
        nx();
        chk(local_addr_data_out, 32'h9ABC_DEF0);
        chk(local_addr_data_oe_out, 1'b1);
        nx();
        chk(done_out, 1'b1);
        chk(busy_out, 1'b0);
        chk(cap, 32'h00BC_00F0);
        req_beats_in = 4'h0;
    endtask
    task automatic t_sread();
        static_bank_in = 1'b0;
        req_addr_in = 32'h0000_3FF8;
        req_beats_in = 4'h2;
        go(2'h0, 1'b0);
        chk(mem_mux_addr_out, 12'hFFE);
        nx();
        chk(mem_mux_addr_out, 12'hFFF);
        nx();
        chk(mem_mux_addr_out, 12'h000);
        chk(static_bank_select_n_out, 2'h2);
        nx();
        chk(done_out, 1'b1);
        req_beats_in = 4'h0;
    endtask
    task automatic t_dread(input logic b);
        bad = b;
        interleave_in = 1'b0;
        dram_bank_in = 2'h2;
        parity_odd_in = 1'b0;
        row_addr_in = 12'h5A5;
        col_addr_in = 12'h3C3;
        byte_lane_enable_n_in = 4'hC;
        go(2'h1, 1'b0);
        chk(row_strobe_n_out, 4'hB);
        chk(mem_mux_addr_out, 12'h5A5);
        nx();
        chk(mem_mux_addr_out, 12'h3C3);
        chk(dram_write_n_out, 2'h3);
        nx();
        chk(col_strobe_n_out, 8'hCC);
        nx();
        chk(done_out, 1'b1);
        chk(row_strobe_n_out, 4'hF);
        chk(parity_err_out, b);
        nx();
        chk(parity_err_out, 1'b0);
        bad = 1'b0;
    endtask
    task automatic t_dwrite();
        interleave_in = 1'b1;
        dram_bank_in = 2'h3;
        parity_odd_in = 1'b1;
        byte_lane_enable_n_in = 4'h0;
        wdata_in = 32'h8001_FF03;
        go(2'h1, 1'b1);
        chk(row_strobe_n_out, 4'h7);
        nx();
        chk(dram_write_n_out, 2'h0);
        chk(byte_parity_out, 4'h3);
        chk(byte_parity_oe_out, 1'b1);
        chk(local_addr_data_out, 32'h8001_FF03);
        chk(local_addr_data_oe_out, 1'b1);
        nx();
        chk(col_strobe_n_out, 8'h0F);
        nx();
        chk(done_out, 1'b1);
        chk(byte_parity_oe_out, 1'b0);
        chk(local_addr_data_oe_out, 1'b0);
    endtask
    task automatic t_refresh();
        go(2'h2, 1'b0);
        chk(col_strobe_n_out, 8'h00);
        chk(row_strobe_n_out, 4'h0);
        nx();
        chk(done_out, 1'b1);
        chk(col_strobe_n_out, 8'hFF);
    endtask
    initial begin
        repeat (6) nx();
        chk(col_strobe_n_out, lmps_pkg::STROBE8_IDLE);
        chk(row_strobe_n_out, lmps_pkg::STROBE4_IDLE);
        chk(mem_mux_addr_out, lmps_pkg::MUX_RESET);
        rst_in = 1'b0;
        nx();
        t_swrite();
        t_sread();
        t_dread(1'b0);
        t_dread(1'b1);
        t_dwrite();
        t_refresh();
        summarize();
    end
endmodule
